/* design/cmd_pkg.sv */
// Constants and carrier types shared by the redundant command decoder
package cmd_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    // Times in ms, cycle counts derived from the clock rate
    localparam int ACQ_MS = 50;
    localparam int ACQ_CYC = ACQ_MS * CYC_PER_MS;
    localparam int DWELL_MS = 20;
    localparam int DWELL_CYC = DWELL_MS * CYC_PER_MS;
    localparam int EXEC_MIN_MS = 5;
    localparam int EXEC_MIN_CYC = EXEC_MIN_MS * CYC_PER_MS;
    localparam int FIRE_MIN_MS = 1000;
    localparam int FIRE_MIN_CYC = FIRE_MIN_MS * CYC_PER_MS;
    localparam int PULSE_MS = 20;
    localparam int PULSE_CYC = PULSE_MS * CYC_PER_MS;
    // Source and command number space
    localparam int NUM_SRC = 4;
    localparam int NUM_RELAY = 60;
    localparam int NUM_LATCH_CMD = 120;
    localparam int NUM_PULSE = 50;
    localparam int MAX_CMD = 254;
    localparam logic [7:0] CMD_NONE = 8'h00;
    localparam logic [7:0] CMD_ALL1 = 8'hFF;
    localparam logic [7:0] PULSE_BASE = 8'h79;
    localparam logic [7:0] ARM_CMD = 8'hAB;
    localparam logic [7:0] FIRE_CMD = 8'hAC;
    localparam logic [7:0] ADDR_CH0 = 8'h5A;
    localparam logic [7:0] ADDR_CH1 = 8'hA5;
    localparam int TLM_W = 9;
    localparam logic [8:0] TLM_RESET = 9'h000;

    typedef struct packed {
        logic [TLM_W-1:0] cmd_word;
        logic [TLM_W-1:0] exec_word;
    } tlm_t;

    typedef struct packed {
        logic [NUM_SRC-1:0] tone;
        logic [NUM_SRC-1:0] snr_ok;
        logic [NUM_SRC-1:0] data;
        logic [NUM_SRC-1:0] strobe;
        logic [NUM_SRC-1:0] exec;
    } rx_t;
endpackage

/* design/relay_bank.sv */
// Latching relay bank: one stored state per relay, registered read-out
`timescale 1ns/10ps
`default_nettype none
module relay_bank #(
    parameter int N = 60,
    parameter int IW = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Write port
    input wire logic we,
    input wire logic [IW-1:0] idx,
    input wire logic val,
    // Stored states
    output logic [N-1:0] state
);
    logic [N-1:0] mem;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            mem <= '0;
        end else if (we && idx < IW'(N)) begin
            mem[idx] <= val;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= mem;
        end
    end
endmodule
`default_nettype wire

/* design/redundant_command_decoder.sv */
// Two redundant command channels with source scanning, merge and relay/pulse outputs
`timescale 1ns/10ps
`default_nettype none
module redundant_command_decoder
    import cmd_pkg::*;
#(
    parameter int ACQ_N = cmd_pkg::ACQ_CYC,
    parameter int DWELL_N = cmd_pkg::DWELL_CYC,
    parameter int EXEC_N = cmd_pkg::EXEC_MIN_CYC,
    parameter int FIRE_N = cmd_pkg::FIRE_MIN_CYC,
    parameter int PULSE_N = cmd_pkg::PULSE_CYC
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RESETN,
    // Receiver baseband indications, asynchronous
    input wire cmd_pkg::rx_t RX,
    // Telemetry verification words and real-time subcarrier shift
    output var cmd_pkg::tlm_t TLM,
    output logic SUBCARRIER_SHIFT,
    // Command function outputs
    output logic [cmd_pkg::NUM_RELAY-1:0] RELAY_OUT,
    output logic [cmd_pkg::NUM_PULSE-1:0] PULSE_OUT,
    output logic FIRE_OUT,
    output logic ARMED,
    // Source selected by each channel
    output logic [1:0] SEL0,
    output logic [1:0] SEL1
);
    import cmd_pkg::*;

    typedef enum logic [3:0] {
        ST_SCAN = 4'h1,
        ST_ADDR = 4'h2,
        ST_NUM = 4'h4,
        ST_HOLD = 4'h8
    } ch_state_t;

    function automatic logic cmd_valid(input logic [7:0] n);
        return n != CMD_NONE && n != CMD_ALL1;
    endfunction

    // Two-stage synchroniser, third stage only for strobe edges
    rx_t rx_a, rx_b;
    logic [NUM_SRC-1:0] strobe_c;
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            rx_a <= '0;
            rx_b <= '0;
            strobe_c <= '0;
        end else begin
            rx_a <= RX;
            rx_b <= rx_a;
            strobe_c <= rx_b.strobe;
        end
    end

    ch_state_t state [2];
    logic [1:0] sel [2];
    logic [31:0] cnt [2];
    logic [31:0] xlen [2];
    logic [7:0] sh [2];
    logic [2:0] bits [2];
    logic [7:0] cmd [2];
    logic go [2];
    logic tone_s [2], snr_s [2], bit_s [2], stb_s [2], exe_s [2];
    logic [7:0] own_addr [2];
    logic [7:0] next_sh [2];

    assign own_addr[0] = ADDR_CH0;
    assign own_addr[1] = ADDR_CH1;

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            tone_s[c] = rx_b.tone[sel[c]];
            snr_s[c] = rx_b.snr_ok[sel[c]];
            bit_s[c] = rx_b.data[sel[c]];
            stb_s[c] = rx_b.strobe[sel[c]] && !strobe_c[sel[c]];
            exe_s[c] = rx_b.exec[sel[c]];
            next_sh[c] = {sh[c][6:0], bit_s[c]};
        end
    end

    // Per-channel scan, acquisition, address and number decoding
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            for (int c = 0; c < 2; c++) begin
                state[c] <= ST_SCAN;
                sel[c] <= 2'(c);
                cnt[c] <= '0;
                xlen[c] <= '0;
                sh[c] <= '0;
                bits[c] <= '0;
                cmd[c] <= CMD_NONE;
                go[c] <= 1'b0;
            end
        end else begin
            for (int c = 0; c < 2; c++) begin
                go[c] <= 1'b0;
                case (state[c])
                    ST_SCAN: begin
                        bits[c] <= '0;
                        if (tone_s[c] && snr_s[c]) begin
                            // Tone above threshold must also last long enough
                            if (cnt[c] >= 32'(ACQ_N - 1)) begin
                                state[c] <= ST_ADDR;
                                cnt[c] <= '0;
                            end else begin
                                cnt[c] <= cnt[c] + 32'h1;
                            end
                        end else if (cnt[c] >= 32'(DWELL_N - 1)) begin
                            sel[c] <= sel[c] + 2'h1;
                            cnt[c] <= '0;
                        end else begin
                            cnt[c] <= tone_s[c] ? '0 : cnt[c] + 32'h1;
                        end
                    end
                    ST_ADDR: begin
                        if (stb_s[c]) begin
                            sh[c] <= next_sh[c];
                            bits[c] <= bits[c] + 3'h1;
                            if (bits[c] == 3'h7) begin
                                // Only the decoder owning this address proceeds
                                state[c] <= (next_sh[c] == own_addr[c]) ? ST_NUM : ST_SCAN;
                            end
                        end
                    end
                    ST_NUM: begin
                        if (stb_s[c]) begin
                            sh[c] <= next_sh[c];
                            bits[c] <= bits[c] + 3'h1;
                            if (bits[c] == 3'h7) begin
                                if (cmd_valid(next_sh[c])) begin
                                    cmd[c] <= next_sh[c];
                                    state[c] <= ST_HOLD;
                                    xlen[c] <= '0;
                                end else begin
                                    state[c] <= ST_SCAN;
                                end
                            end
                        end
                    end
                    ST_HOLD: begin
                        // Waits for the ground to verify before executing
                        if (exe_s[c]) begin
                            if (xlen[c] != 32'hFFFF_FFFF) begin
                                xlen[c] <= xlen[c] + 32'h1;
                            end
                        end else if (xlen[c] != '0) begin
                            // Act at tone end, so duration is known for critical commands
                            go[c] <= xlen[c] >= 32'(EXEC_N);
                            state[c] <= ST_SCAN;
                            cnt[c] <= '0;
                        end
                    end
                    default: state[c] <= ST_SCAN;
                endcase
            end
        end
    end

    // Merge stage: channel 0 takes precedence when both complete together
    logic any_go, win;
    logic [7:0] win_cmd;
    logic [31:0] win_len;
    assign any_go = go[0] || go[1];
    assign win = !go[0];
    assign win_cmd = cmd[win];
    assign win_len = xlen[win];

    logic relay_we, relay_val;
    logic [5:0] relay_idx;
    logic [7:0] lin_cmd;
    logic [7:0] pidx;
    assign lin_cmd = win_cmd - 8'h01;
    assign pidx = win_cmd - PULSE_BASE;

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            relay_we <= 1'b0;
            relay_val <= 1'b0;
            relay_idx <= '0;
        end else begin
            // Odd number energises, even number releases the same relay
            relay_we <= any_go && win_cmd <= 8'(NUM_LATCH_CMD);
            relay_val <= !lin_cmd[0];
            relay_idx <= lin_cmd[6:1];
        end
    end

    relay_bank #(.N(NUM_RELAY), .IW(6)) u_relays (
        .clk(CLOCK),
        .resetn(RESETN),
        .we(relay_we),
        .idx(relay_idx),
        .val(relay_val),
        .state(RELAY_OUT)
    );

    // Momentary outputs share one width timer
    logic [31:0] pcnt;
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            PULSE_OUT <= '0;
            FIRE_OUT <= 1'b0;
            ARMED <= 1'b0;
            pcnt <= '0;
        end else if (any_go && win_cmd >= PULSE_BASE
                     && win_cmd < PULSE_BASE + 8'(NUM_PULSE)) begin
            PULSE_OUT <= '0;
            PULSE_OUT[pidx[5:0]] <= 1'b1;
            pcnt <= 32'(PULSE_N);
        end else if (any_go && win_cmd == ARM_CMD) begin
            ARMED <= 1'b1;
        end else if (any_go && win_cmd == FIRE_CMD && ARMED
                     && win_len >= 32'(FIRE_N)) begin
            FIRE_OUT <= 1'b1;
            ARMED <= 1'b0;
            pcnt <= 32'(PULSE_N);
        end else if (pcnt > 32'h1) begin
            pcnt <= pcnt - 32'h1;
        end else begin
            PULSE_OUT <= '0;
            FIRE_OUT <= 1'b0;
            pcnt <= '0;
        end
    end

    // Telemetry verification and real-time execute indication
    logic exec_now;
    assign exec_now = (state[0] == ST_HOLD && exe_s[0]) || (state[1] == ST_HOLD && exe_s[1]);
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            TLM <= {TLM_RESET, TLM_RESET};
            SUBCARRIER_SHIFT <= 1'b0;
            SEL0 <= '0;
            SEL1 <= '0;
        end else begin
            TLM.cmd_word <= {state[0] == ST_HOLD || state[1] == ST_HOLD,
                             (state[1] == ST_HOLD) ? cmd[1] : cmd[0]};
            TLM.exec_word <= {8'h00, exec_now};
            SUBCARRIER_SHIFT <= exec_now;
            SEL0 <= sel[0];
            SEL1 <= sel[1];
        end
    end

    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);

    property p_exec_bit;
        exec_now |=> TLM.exec_word[0] && SUBCARRIER_SHIFT;
    endproperty
    a_exec_bit: assert property (p_exec_bit) else $error("execute bit not set");

    property p_no_exec_shift;
        !exec_now |=> !SUBCARRIER_SHIFT && TLM.exec_word == 9'h000;
    endproperty
    a_no_exec_shift: assert property (p_no_exec_shift) else $error("stray execute bit");

    property p_fire_armed;
        $rose(FIRE_OUT) |-> $past(ARMED) && !ARMED;
    endproperty
    a_fire_armed: assert property (p_fire_armed) else $error("fire without arm");

    property p_fire_long;
        $rose(FIRE_OUT) |-> $past(win_len) >= 32'(FIRE_N);
    endproperty
    a_fire_long: assert property (p_fire_long) else $error("fire on short tone");

    property p_mismatch0;
        state[0] == ST_ADDR && stb_s[0] && bits[0] == 3'h7 && next_sh[0] != ADDR_CH0
            |=> state[0] == ST_SCAN;
    endproperty
    a_mismatch0: assert property (p_mismatch0) else $error("no return to standby");

    property p_step0;
        state[0] == ST_SCAN && !tone_s[0] && cnt[0] >= 32'(DWELL_N - 1)
            |=> sel[0] == $past(sel[0]) + 2'h1;
    endproperty
    a_step0: assert property (p_step0) else $error("source not stepped");

    property p_cmd_word;
        state[0] == ST_NUM ##1 state[0] == ST_HOLD && state[1] != ST_HOLD
            |=> TLM.cmd_word == {1'b1, cmd[0]};
    endproperty
    a_cmd_word: assert property (p_cmd_word) else $error("command word wrong");

    property p_relay_cause;
        $changed(RELAY_OUT) |-> $past(any_go, 3);
    endproperty
    a_relay_cause: assert property (p_relay_cause) else $error("relay moved unbidden");

    property p_pulse_cause;
        $rose(|PULSE_OUT) |-> $past(any_go);
    endproperty
    a_pulse_cause: assert property (p_pulse_cause) else $error("pulse unbidden");

    property p_valid_cmd;
        state[0] == ST_HOLD |-> cmd_valid(cmd[0]);
    endproperty
    a_valid_cmd: assert property (p_valid_cmd) else $error("invalid number held");

    c_acquire: cover property (state[0] == ST_SCAN ##1 state[0] == ST_ADDR);
    c_hold: cover property (state[1] == ST_NUM ##1 state[1] == ST_HOLD);
    c_fire: cover property ($rose(FIRE_OUT));
    c_relay: cover property ($changed(RELAY_OUT));
endmodule
`default_nettype wire

/* test/ground_station_model.sv */
// Ground station seen through the four receivers: intro tone, address, number, execute
`timescale 1ns/10ps
`default_nettype none
module ground_station_model #(
    parameter int ACQ_LEN = 24
) (
    // Clock
    input wire logic clk,
    // Receiver baseband outputs, all four alike
    output var cmd_pkg::rx_t rx
);
    import cmd_pkg::*;

    initial rx = '0;

    task automatic set_tone(input logic tone, input logic snr);
        @(negedge clk);
        rx.tone <= {4{tone}};
        rx.snr_ok <= {4{snr}};
    endtask

    task automatic set_exec(input logic on);
        @(negedge clk);
        rx.exec <= {4{on}};
    endtask

    task automatic send_cmd(input logic [7:0] addr, input logic [7:0] num);
        logic [15:0] bits;
        bits = {addr, num};
        set_tone(1'b1, 1'b1);
        repeat (ACQ_LEN) @(negedge clk);
        // Tone dropped before the bits so a rejected channel cannot reacquire mid-message
        rx.tone <= 4'h0;
        rx.snr_ok <= 4'h0;
        for (int i = 15; i >= 0; i--) begin
            rx.data <= {4{bits[i]}};
            rx.strobe <= 4'hF;
            repeat (2) @(negedge clk);
            rx.strobe <= 4'h0;
            repeat (2) @(negedge clk);
        end
        // Released data line must not keep showing the last bit
        rx.data <= ~rx.data;
    endtask
endmodule
`default_nettype wire

/* test/redundant_command_decoder_tb.sv */
// Self-checking bench for the redundant command decoder
`timescale 1ns/10ps
`default_nettype none
module redundant_command_decoder_tb;
    import cmd_pkg::*;
    localparam int ACQ = 20;
    localparam int DWELL = 30;
    localparam int EXN = 4;
    localparam int FIRN = 40;
    localparam int PULN = 5;
    logic clock;
    logic resetn;
    rx_t rx;
    tlm_t tlm;
    logic subcarrier_shift;
    logic [NUM_RELAY-1:0] relay_out;
    logic [NUM_RELAY-1:0] relays;
    logic [NUM_PULSE-1:0] pulse_out;
    logic fire_out;
    logic armed;
    logic [1:0] sel0;
    logic [1:0] sel1;
    int mismatches = 0;
    int total_checks = 0;

    ground_station_model #(.ACQ_LEN(ACQ + 4)) gs (.clk(clock), .rx(rx));

    redundant_command_decoder #(.ACQ_N(ACQ), .DWELL_N(DWELL), .EXEC_N(EXN), .FIRE_N(FIRN),
        .PULSE_N(PULN)) DUT (
        .CLOCK(clock), .RESETN(resetn), .RX(rx), .TLM(tlm),
        .SUBCARRIER_SHIFT(subcarrier_shift), .RELAY_OUT(relay_out), .PULSE_OUT(pulse_out),
        .FIRE_OUT(fire_out), .ARMED(armed), .SEL0(sel0), .SEL1(sel1));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic stop_test();
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // Three edges flush the input synchronisers
    task automatic do_reset();
        @(negedge clock);
        resetn <= 1'b0;
        repeat (3) @(negedge clock);
        resetn <= 1'b1;
        @(negedge clock);
        relays = '0;
    endtask

    task automatic run_exec(input int len);
        gs.set_exec(1'b1);
        repeat (len - 1) @(negedge clock);
        if (len > EXN) check({subcarrier_shift, tlm.exec_word}, 10'h201);
        gs.set_exec(1'b0);
    endtask

    // One full transfer: load, verify, execute, then watch the outputs
    task automatic cmd(input logic [7:0] addr, input logic [7:0] num, input logic held,
                       input int len, input logic [NUM_PULSE-1:0] pexp, input logic fexp);
        int np, nm, nf, ep, ef;
        np = 0;
        nm = 0;
        nf = 0;
        gs.send_cmd(addr, num);
        repeat (8) @(negedge clock);
        if (held) check(tlm.cmd_word, {1'b1, num});
        else check(tlm.cmd_word[8], 1'b0);
        check(relay_out, relays);
        if (!held) return;
        run_exec(len);
        repeat (14) begin
            @(negedge clock);
            if (pulse_out !== '0) np++;
            if (pulse_out === pexp) nm++;
            if (fire_out === 1'b1) nf++;
        end
        if (len > EXN && num >= 8'h01 && num <= 8'h78) relays[(num - 8'h01) >> 1] = num[0];
        ep = (pexp === '0) ? 0 : PULN;
        ef = fexp ? PULN : 0;
        check(relay_out, relays);
        check({np, nf}, {ep, ef});
        if (pexp !== '0) check(nm, PULN);
        if (len > EXN) check({tlm.cmd_word[8], subcarrier_shift, tlm.exec_word}, 11'h000);
    endtask

    task automatic test_relays();
        logic [7:0] nums [5];
        nums = '{8'h01, 8'h78, 8'h03, 8'h04, 8'h02};
        do_reset();
        for (int i = 0; i < 5; i++) begin
            cmd((i % 2) ? ADDR_CH1 : ADDR_CH0, nums[i], 1'b1, 8, '0, 1'b0);
        end
    endtask

    task automatic test_pulses();
        logic [7:0] nums [3];
        logic [NUM_PULSE-1:0] pv;
        nums = '{8'h79, 8'h90, 8'hAA};
        do_reset();
        for (int i = 0; i < 3; i++) begin
            pv = '0;
            pv[nums[i] - 8'h79] = 1'b1;
            cmd(ADDR_CH1, nums[i], 1'b1, 8, pv, 1'b0);
        end
    endtask

    task automatic test_refusals();
        do_reset();
        cmd(ADDR_CH0, 8'h00, 1'b0, 8, '0, 1'b0);
        cmd(ADDR_CH1, 8'hFF, 1'b0, 8, '0, 1'b0);
        cmd(8'h33, 8'h05, 1'b0, 8, '0, 1'b0);
        cmd(ADDR_CH0, 8'h07, 1'b1, 2, '0, 1'b0);
    endtask

    task automatic test_critical();
        do_reset();
        cmd(ADDR_CH0, FIRE_CMD, 1'b1, 50, '0, 1'b0);
        check(armed, 1'b0);
        cmd(ADDR_CH0, ARM_CMD, 1'b1, 8, '0, 1'b0);
        check(armed, 1'b1);
        cmd(ADDR_CH1, FIRE_CMD, 1'b1, 20, '0, 1'b0);
        cmd(ADDR_CH0, FIRE_CMD, 1'b1, 50, '0, 1'b1);
        check(armed, 1'b0);
    endtask

    task automatic test_scan();
        do_reset();
        check({sel0, sel1}, 4'h1);
        repeat (DWELL + 6) @(negedge clock);
        check({sel0, sel1}, 4'h6);
        gs.set_tone(1'b1, 1'b0);
        repeat (2 * DWELL) @(negedge clock);
        check({sel0, sel1, tlm.cmd_word[8]}, 5'h0C);
        gs.set_tone(1'b0, 1'b0);
    endtask

    // Whole run needs a few thousand cycles
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        stop_test();
    end

    initial begin
        resetn = 1'b0;
        test_scan();
        test_relays();
        test_pulses();
        test_refusals();
        test_critical();
        stop_test();
    end
endmodule
`default_nettype wire
